// [common/panel_timing_pkg.sv]
// Constants for the RGB panel timing controller
//
// Contract
// - Line sync active low, idle high
// - Frame sync active low, idle high
// - Data enable marks valid pixels, else low
// - Pixel clock at most 15 MHz
// - Exactly 480 active pixels per line
// - Exactly 272 active lines per frame
// - Line period at most 605 clocks
// - Line sync, porches within documented clock bounds
// - Frame period 285 to 399 lines
// - Frame sync, porches within documented line bounds
// - Sync mode: sync plus porch 12/43
// - Data-enable mode locates pixels by enable
`default_nettype none

package panel_timing_pkg;

    // ========================================================
    // Clock rates
    localparam int SYS_CLK_HZ       = 100_000_000;
    localparam int PIX_CLK_MAX_HZ   = 15_000_000;
    // Divide by 10 gives 10 MHz, near the 9 MHz typical
    localparam int PIX_DIV          = 10;
    localparam int PIX_HALF         = PIX_DIV / 2;
    localparam int PIX_CLK_HZ       = SYS_CLK_HZ / PIX_DIV;

    // ========================================================
    // Pixel format
    localparam int COLOR_W          = 8;
    localparam int PIXEL_W          = 3 * COLOR_W;

    // ========================================================
    // Horizontal timing, pixel clocks
    localparam int H_ACTIVE         = 480;
    localparam int H_SYNC           = 41;
    localparam int H_BACK           = 2;
    localparam int H_FRONT          = 2;
    localparam int H_TOTAL          = H_SYNC + H_BACK + H_ACTIVE + H_FRONT;
    localparam int H_TOTAL_MAX      = 605;

    // ========================================================
    // Vertical timing, lines
    localparam int V_ACTIVE         = 272;
    localparam int V_SYNC           = 10;
    localparam int V_BACK           = 2;
    localparam int V_FRONT          = 2;
    localparam int V_TOTAL          = V_SYNC + V_BACK + V_ACTIVE + V_FRONT;

    // ========================================================
    // Counter widths and reset values
    localparam int CNT_W            = 10;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    localparam logic [PIXEL_W-1:0] PIXEL_RST = 24'h00_0000;

    // ========================================================
    // Interface modes
    typedef enum logic [1:0] {
        MODE_SYNC = 2'b00,
        MODE_DE   = 2'b01,
        MODE_BOTH = 2'b11
    } mode_t;

endpackage : panel_timing_pkg

`default_nettype wire

// [verilog/pix_clk_gen.sv]
// Pixel clock divider with rising and falling strobes
`default_nettype none

module pix_clk_gen
    import panel_timing_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Divided clock and strobes
    output var  logic pclk_reg,
    output var  logic rise_reg,
    output var  logic fall_reg
);

    logic [CNT_W-1:0] div_reg;

    // ========================================================
    // Divider
    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg  <= CNT_RST;
            pclk_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            if (div_reg == CNT_W'(PIX_HALF - 1)) begin
                div_reg  <= CNT_RST;
                pclk_reg <= ~pclk_reg;
                rise_reg <= ~pclk_reg;
                fall_reg <= pclk_reg;
            end else begin
                div_reg <= div_reg + CNT_W'(1);
            end
        end
    end

endmodule : pix_clk_gen

`default_nettype wire

// [verilog/raster_counter.sv]
// Horizontal and vertical position counters
`default_nettype none

module raster_counter
    import panel_timing_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Advance by one pixel clock
    input  wire logic             step,
    input  wire logic             run,
    // Position
    output var  logic [CNT_W-1:0] hpos_reg,
    output var  logic [CNT_W-1:0] vpos_reg
);

    // ========================================================
    // Counters
    // line period
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            hpos_reg <= CNT_RST;
        end else if (step) begin
            if (hpos_reg == CNT_W'(H_TOTAL - 1)) begin
                hpos_reg <= CNT_RST;
            end else begin
                hpos_reg <= hpos_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !run) begin
            vpos_reg <= CNT_RST;
        end else if (step && hpos_reg == CNT_W'(H_TOTAL - 1)) begin
            if (vpos_reg == CNT_W'(V_TOTAL - 1)) begin
                vpos_reg <= CNT_RST;
            end else begin
                vpos_reg <= vpos_reg + CNT_W'(1);
            end
        end
    end

endmodule : raster_counter

`default_nettype wire

// [verilog/rgb_panel_driver.sv]
// Host timing controller driving a parallel RGB panel
`default_nettype none

module rgb_panel_driver
    import panel_timing_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // User control
    input  wire logic                     enable,
    input  wire panel_timing_pkg::mode_t  mode,
    // Pixel source
    input  wire logic [COLOR_W-1:0]       src_red,
    input  wire logic [COLOR_W-1:0]       src_green,
    input  wire logic [COLOR_W-1:0]       src_blue,
    output var  logic                     src_req,
    output var  logic [CNT_W-1:0]         src_x,
    output var  logic [CNT_W-1:0]         src_y,
    // Panel pins
    output var  logic                     pixel_sample_clock,
    output var  logic                     display_on_control,
    output var  logic                     line_sync_n,
    output var  logic                     frame_sync_n,
    output var  logic                     data_enable_qualifier,
    output var  logic [COLOR_W-1:0]       red_bits,
    output var  logic [COLOR_W-1:0]       green_bits,
    output var  logic [COLOR_W-1:0]       blue_bits,
    // Status
    output var  logic                     frame_start
);

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_RUN  = 2'b01,
        ST_STOP = 2'b11
    } state_t;

    state_t           state_reg;
    logic             pclk;
    logic             fall;
    logic [CNT_W-1:0] hpos;
    logic [CNT_W-1:0] vpos;
    logic             run;
    logic             h_act;
    logic             v_act;
    logic             use_sync;
    logic             use_de;

    // ========================================================
    // Pixel clock, 10 MHz keeps below the 15 MHz ceiling
    // clock limit
    pix_clk_gen u_clk (
        .clk      (clk),
        .rst      (rst),
        .pclk_reg (pclk),
        .rise_reg (),
        .fall_reg (fall)
    );

    // Counters step on the falling strobe so sync and enable pins settle 4 system
    // clocks, colour pins 2, before the panel's rising sample
    raster_counter u_cnt (
        .clk      (clk),
        .rst      (rst),
        .step     (fall),
        .run      (run),
        .hpos_reg (hpos),
        .vpos_reg (vpos)
    );

    // ========================================================
    // Control state
    assign run = (state_reg == ST_RUN);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    // Start on a falling strobe so the first pixel
                    // spans a full clock and line one keeps 41+2
                    if (enable && fall) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Stop only at frame end so no partial frame shows
                    if (!enable && fall
                        && hpos == CNT_W'(H_TOTAL - 1)
                        && vpos == CNT_W'(V_TOTAL - 1)) begin
                        state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    state_reg <= ST_OFF;
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // ========================================================
    // Mode decode
    // mode selection
    assign use_sync = (mode != MODE_DE);
    assign use_de   = (mode != MODE_SYNC);

    assign h_act = (hpos >= CNT_W'(H_SYNC + H_BACK))
                && (hpos <  CNT_W'(H_SYNC + H_BACK + H_ACTIVE));
    assign v_act = (vpos >= CNT_W'(V_SYNC + V_BACK))
                && (vpos <  CNT_W'(V_SYNC + V_BACK + V_ACTIVE));

    // ========================================================
    // Pin outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            pixel_sample_clock <= 1'b0;
        end else begin
            pixel_sample_clock <= pclk;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            display_on_control <= 1'b0;
        end else begin
            display_on_control <= run;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            line_sync_n  <= 1'b1;
            frame_sync_n <= 1'b1;
        end else begin
            line_sync_n  <= !(run && use_sync && hpos < CNT_W'(H_SYNC));
            frame_sync_n <= !(run && use_sync && vpos < CNT_W'(V_SYNC));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_enable_qualifier <= 1'b0;
        end else begin
            data_enable_qualifier <= run && use_de && h_act && v_act;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            red_bits   <= PIXEL_RST[3*COLOR_W-1:2*COLOR_W];
            green_bits <= PIXEL_RST[2*COLOR_W-1:COLOR_W];
            blue_bits  <= PIXEL_RST[COLOR_W-1:0];
        end else if (!(run && h_act && v_act)) begin
            red_bits   <= PIXEL_RST[3*COLOR_W-1:2*COLOR_W];
            green_bits <= PIXEL_RST[2*COLOR_W-1:COLOR_W];
            blue_bits  <= PIXEL_RST[COLOR_W-1:0];
        end else begin
            red_bits   <= src_red;
            green_bits <= src_green;
            blue_bits  <= src_blue;
        end
    end

    // ========================================================
    // Pixel source request, sampled one system cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            src_req <= 1'b0;
            src_x   <= CNT_RST;
            src_y   <= CNT_RST;
        end else begin
            src_req <= fall && run && h_act && v_act;
            src_x   <= hpos - CNT_W'(H_SYNC + H_BACK);
            src_y   <= vpos - CNT_W'(V_SYNC + V_BACK);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_start <= 1'b0;
        end else begin
            frame_start <= run && fall && hpos == CNT_RST
                        && vpos == CNT_RST;
        end
    end

endmodule : rgb_panel_driver

`default_nettype wire

// [tb/rgb_panel_monitor.sv]
// Pin-level checker for the RGB panel driver
`default_nettype none
module rgb_panel_monitor
    import panel_timing_pkg::*;
(
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rst,
    // Control
    input wire logic                    enable,
    input wire panel_timing_pkg::mode_t mode,
    // Panel pins
    input wire logic                    pixel_sample_clock,
    input wire logic                    display_on_control,
    input wire logic                    line_sync_n,
    input wire logic                    frame_sync_n,
    input wire logic                    data_enable_qualifier,
    input wire logic [COLOR_W-1:0]      red_bits,
    input wire logic [COLOR_W-1:0]      green_bits,
    input wire logic [COLOR_W-1:0]      blue_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HS_CLKS = H_SYNC * PIX_DIV;
    localparam int LN_CLKS = H_TOTAL * PIX_DIV;
    localparam int DE_CLKS = H_ACTIVE * PIX_DIV;
    wire de = data_enable_qualifier;
    wire hs = line_sync_n;
    wire vs = frame_sync_n;
    wire pc = pixel_sample_clock;
    // ========
    // Run-length counters, so long spans need no deep repetition
    logic [15:0] de_cnt_reg;
    logic [15:0] hs_cnt_reg;
    logic [15:0] ln_cnt_reg;
    logic [7:0]  vs_cnt_reg;
    logic        hs_q_reg;
    wire hs_fall = hs_q_reg && !hs;
    always_ff @(posedge clk) begin
        hs_q_reg   <= rst | hs;
        de_cnt_reg <= (rst | !de) ? 16'h0000 : de_cnt_reg + 16'h0001;
        hs_cnt_reg <= (rst | hs) ? 16'h0000 : hs_cnt_reg + 16'h0001;
        vs_cnt_reg <= (rst | vs) ? 8'h00 : vs_cnt_reg + 8'(hs_fall);
    end
    always_ff @(posedge clk) begin
        if (rst)
            ln_cnt_reg <= 16'h0000;
        else if (hs_fall)
            ln_cnt_reg <= 16'h0001;
        else if (ln_cnt_reg != 16'h0000)
            ln_cnt_reg <= ln_cnt_reg + 16'h0001;
    end
    // ========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_SYNC_NO_DE: assert property (
        mode == MODE_SYNC |-> !de) else $error("enable in sync mode");
    AST_DE_SYNC_IDLE: assert property (
        mode == MODE_DE |-> hs && vs) else $error("sync low in DE mode");
    AST_DATA_ZERO: assert property (
        mode != MODE_SYNC && !de |-> {red_bits, green_bits, blue_bits}
        == PIXEL_RST) else $error("data outside active area");
    AST_PCLK_DUTY: assert property (
        $rose(pc) |-> pc [*5] ##1 !pc [*5]) else $error("pixel clock shape");
    AST_HS_WIDTH: assert property (
        $rose(hs) |-> hs_cnt_reg == HS_CLKS) else $error("line sync width");
    AST_LINE_PERIOD: assert property (
        hs_fall && ln_cnt_reg != 0 |-> ln_cnt_reg == LN_CLKS)
        else $error("line period");
    AST_DE_LEN: assert property (
        $fell(de) |-> de_cnt_reg == DE_CLKS) else $error("active length");
    AST_VS_WIDTH: assert property (
        $rose(vs) |-> vs_cnt_reg == V_SYNC) else $error("frame sync width");
    AST_DISPLAY_ON_CONTROL_ON: assert property (
        $rose(enable) |-> ##[1:20] display_on_control)
        else $error("display on late");
endmodule : rgb_panel_monitor
`default_nettype wire

// [tb/panel_model.sv]
// Behavioural panel that samples the RGB pins
`default_nettype none
module panel_model
    import panel_timing_pkg::*;
(
    // Panel pins
    input  wire logic               pixel_sample_clock,
    input  wire logic               display_on_control,
    input  wire logic               line_sync_n,
    input  wire logic               frame_sync_n,
    input  wire logic               data_enable_qualifier,
    input  wire logic [COLOR_W-1:0] red_bits,
    input  wire logic [COLOR_W-1:0] green_bits,
    input  wire logic [COLOR_W-1:0] blue_bits,
    // Measurements
    output var  logic               standby,
    output var  logic [PIXEL_W-1:0] cap_pix,
    output var  int                 cap_col,
    output var  int                 cap_cnt,
    output var  int                 hs_w,
    output var  int                 line_len,
    output var  int                 de_off,
    output var  int                 de_len,
    output var  int                 de_line,
    output var  int                 vs_w,
    output var  int                 falls,
    output var  int                 pclk_ns
);
    timeunit 1ns;
    timeprecision 1ps;
    int      hpos, hs_lo, vs_lo, lines, col;
    logic    hs_q = 1'b1, vs_q = 1'b1, de_q = 1'b0, seen = 1'b0;
    realtime t_last = 0;
    assign standby = !display_on_control;
    always @(posedge pixel_sample_clock) begin
        pclk_ns = int'($realtime - t_last);
        t_last = $realtime;
        hpos++;
        if (!line_sync_n)
            hs_lo++;
        else if (hs_lo != 0)
            hs_w = hs_lo;
        if (line_sync_n)
            hs_lo = 0;
        if (vs_q && !frame_sync_n)
            lines = 0;
        if (vs_q && !frame_sync_n)
            vs_lo = 0;
        if (!vs_q && frame_sync_n)
            vs_w = vs_lo;
        if (hs_q && !line_sync_n) begin
            // Only the first line since time zero is skipped; a restart's first line spans the idle gap
            if (seen)
                line_len = hpos;
            seen = 1'b1;
            hpos = 0;
            lines++;
            falls++;
            vs_lo += int'(!frame_sync_n);
        end
        if (data_enable_qualifier) begin
            if (!de_q)
                de_off = hpos;
            if (!de_q)
                de_line = lines - 1;
            col = de_q ? col : 0;
            cap_pix = {red_bits, green_bits, blue_bits};
            cap_col = col;
            col++;
            cap_cnt++;
        end else if (de_q)
            de_len = col;
        hs_q = line_sync_n;
        vs_q = frame_sync_n;
        de_q = data_enable_qualifier;
    end
endmodule : panel_model
`default_nettype wire

// [tb/tb.sv]
// Top testbench for the RGB panel driver
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import panel_timing_pkg::*;
    logic clk = 1'b0, rst = 1'b1, enable = 1'b0;
    mode_t mode = MODE_BOTH;
    logic [COLOR_W-1:0] src_red = 8'h00, src_green = 8'h00, src_blue = 8'h00;
    logic [COLOR_W-1:0] red_bits, green_bits, blue_bits;
    logic [CNT_W-1:0]   src_x, src_y;
    logic               src_req, frame_start;
    int reqs = 0, starts = 0;
    logic               pixel_sample_clock, display_on_control, standby;
    logic               line_sync_n, frame_sync_n, data_enable_qualifier;
    logic [PIXEL_W-1:0] cap_pix;
    logic [PIXEL_W-1:0] tbl [H_ACTIVE];
    int cap_col, cap_cnt, hs_w, line_len, de_off, de_len, de_line, vs_w;
    int falls, pclk_ns, n0;
    int failures = 0;
    int checks = 0;
    rgb_panel_driver u_rgb_panel_driver (.clk, .rst, .enable, .mode,
        .src_red, .src_green, .src_blue, .src_req, .src_x, .src_y,
        .pixel_sample_clock, .display_on_control, .line_sync_n,
        .frame_sync_n, .data_enable_qualifier, .red_bits, .green_bits,
        .blue_bits, .frame_start);
    panel_model u_panel_model (.pixel_sample_clock, .display_on_control,
        .line_sync_n, .frame_sync_n, .data_enable_qualifier, .red_bits,
        .green_bits, .blue_bits, .standby, .cap_pix, .cap_col, .cap_cnt,
        .hs_w, .line_len, .de_off, .de_len, .de_line, .vs_w, .falls,
        .pclk_ns);
    initial forever #5 clk = ~clk;
    // Source image is a random row indexed by column
    always @(posedge clk)
        {src_red, src_green, src_blue} <= tbl[src_x < H_ACTIVE ? src_x : 0];
    // Pulse counters for the source request and frame start outputs
    always @(posedge clk) begin
        reqs   <= reqs + int'(src_req);
        starts <= starts + int'(frame_start);
    end
    // ========
    // Checking and control tasks
    task automatic cmp_int(string what, int exp, int got);
        checks++;
        if (exp != got) begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_int
    task automatic cmp_vec(string what, logic [PIXEL_W-1:0] exp, got);
        checks++;
        if (exp !== got) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_vec
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic start(mode_t m);
        rst <= 1'b1;
        enable <= 1'b0;
        mode <= m;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp_vec("standby", 1, standby);
        enable <= 1'b1;
        n0 = 0;
    endtask : start
    // Wait a moment so every model output of this sample has landed
    always @(cap_cnt)
        #1 cmp_vec("pixel", tbl[cap_col], cap_pix);
    initial begin
        #900_000;
        failures++;
        tally_and_finish();
    end
    // ========
    // Scenarios
    initial begin
        void'($urandom(32'h8a3b_122d));
        foreach (tbl[i])
            tbl[i] = PIXEL_W'($urandom);
        start(MODE_BOTH);
        repeat (20000) @(posedge clk);
        // Stop request mid-frame must be ignored
        enable <= 1'b0;
        for (int i = 0; i < 60000 && de_len == 0; i++)
            @(posedge clk);
        cmp_int("line sync width", H_SYNC, hs_w);
        cmp_int("line period", H_TOTAL, line_len);
        cmp_int("enable offset", 43, de_off);
        cmp_int("active pixels", 480, de_len);
        cmp_int("first active line", 12, de_line);
        cmp_int("frame sync width", V_SYNC, vs_w);
        cmp_int("pclk period", 1_000_000_000 / PIX_CLK_HZ, pclk_ns);
        cmp_vec("display on", 1, display_on_control);
        cmp_int("source requests", H_ACTIVE, reqs);
        cmp_int("frame starts", 1, starts);
        cmp_int("source line", 0, src_y);
        start(MODE_SYNC);
        n0 = cap_cnt;
        repeat (6000) @(posedge clk);
        cmp_int("sync mode captures", n0, cap_cnt);
        cmp_int("sync mode period", 525, line_len);
        start(MODE_DE);
        n0 = falls;
        repeat (6000) @(posedge clk);
        cmp_int("DE mode sync falls", n0, falls);
        tally_and_finish();
    end
endmodule : tb
bind rgb_panel_driver rgb_panel_monitor u_rgb_panel_monitor (.clk, .rst,
    .enable, .mode, .pixel_sample_clock, .display_on_control, .line_sync_n,
    .frame_sync_n, .data_enable_qualifier, .red_bits, .green_bits,
    .blue_bits);
`default_nettype wire
